// [core/msp_meter_status.sv]
// msp_meter_status: fault alarm, reverse flag, supply monitor and pulse outputs
// assumes digitised current and voltage samples with a one-cycle valid strobe
// Contract
// - alarm high when the two current inputs differ over 6.25 percent
// - alarm high when powered with no voltage present
// - alarm returns low once neither condition is detected
// - reverse flag high while active power is negative
// - reverse flag not latched, clears on positive power
// - reverse flag changes only together with a calibration pulse
// - calibration output pulses at rate of instantaneous active power
// - two low-rate outputs pulse at rate of average active power
// - below about 4 V no accumulation and pulse outputs disabled
// - supply decision uses hysteresis and filtering
// - exactly one current input feeds the power calculation
`timescale 1ns/1ps
`default_nettype none
module msp_meter_status (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        sample_valid,
  input  wire logic [23:0] current_input_a,
  input  wire logic [23:0] current_input_b,
  input  wire logic [23:0] voltage_sample,
  input  wire logic [23:0] no_neutral_cal_input,
  input  wire logic [12:0] supply_mv,
  input  wire logic        cal_rate_select,
  input  wire logic        rate_select_hi,
  input  wire logic        rate_select_lo,
  output var  logic        fault_alarm,
  output var  logic        reverse_power_flag,
  output var  logic        calibration_pulse_out,
  output var  logic        low_rate_pulse_a,
  output var  logic        low_rate_pulse_b,
  output var  logic        supply_ok,
  output var  logic        using_input_b
);
  logic [23:0] mag_a;
  logic [23:0] mag_b;
  logic [23:0] mag_v;
  logic [23:0] mag_big;
  logic [23:0] mag_diff;
  logic        mismatch;
  logic        neutral_missing;
  logic signed [23:0] cur_sel;
  logic signed [47:0] inst_power;
  logic signed [39:0] avg_power_reg;
  logic signed [39:0] cal_acc_reg;
  logic signed [39:0] low_acc_reg;
  logic signed [39:0] cal_acc_next;
  logic signed [39:0] low_acc_next;
  logic        cal_fire;
  logic        low_fire;
  logic        neg_now;
  logic [11:0] filt_cnt_reg;
  logic        sel_b_reg;
  msp_pkg::msp_phase_e phase_reg;
  int unsigned cal_bit;
  int unsigned low_bit;
  logic [23:0] mag_limit;
  logic        volt_absent;
  logic        supply_high;
  logic        supply_low;
  logic        filt_done;
  logic        sup_against;
  logic        low_trig_a;
  logic        low_trig_b;
  logic signed [39:0] cal_limit;
  logic signed [39:0] low_limit;
  logic signed [39:0] cal_step;
  logic signed [39:0] low_step;
  logic signed [39:0] avg_step;
  typedef enum logic {MSP_SUP_OFF, MSP_SUP_ON} msp_supply_e;
  msp_supply_e sup_state_reg;

  ////////////////////////////////////////////////////////////////////////
  // magnitudes and fault detection
  // two's complement magnitude of each signed sample
  always_comb begin
    mag_a = current_input_a[23] ? 24'(-current_input_a) : current_input_a;
    mag_b = current_input_b[23] ? 24'(-current_input_b) : current_input_b;
    mag_v = voltage_sample[23] ? 24'(-voltage_sample) : voltage_sample;
  end

  // larger current and the gap between the two currents
  always_comb begin
    if (mag_a >= mag_b) begin
      mag_big  = mag_a;
      mag_diff = mag_a - mag_b;
    end else begin
      mag_big  = mag_b;
      mag_diff = mag_b - mag_a;
    end
  end

  // gap against one sixteenth of the larger current
  always_comb begin
    mag_limit = mag_big >> msp_pkg::MISMATCH_SHIFT;
    mismatch  = mag_diff > mag_limit;
  end

  // missing neutral: powered but no voltage at the input
  always_comb begin
    volt_absent     = mag_v < msp_pkg::VOLT_ABSENT_LVL;
    neutral_missing = supply_ok && volt_absent;
  end

  // alarm set and cleared straight from the live conditions
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fault_alarm <= 1'b0;
    end else if (sample_valid) begin
      fault_alarm <= mismatch || neutral_missing;
    end
  end

  // bill on the larger current; held steady between samples
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_b_reg <= 1'b0;
    end else if (sample_valid) begin
      sel_b_reg <= mag_b > mag_a;
    end
  end
  assign using_input_b = sel_b_reg;

  ////////////////////////////////////////////////////////////////////////
  // supply monitor with hysteresis and a qualify filter
  // supply level against the on and off thresholds
  always_comb begin
    supply_high = supply_mv >= msp_pkg::SUPPLY_ON_MV;
    supply_low  = supply_mv < msp_pkg::SUPPLY_OFF_MV;
    filt_done   = filt_cnt_reg >= msp_pkg::SUPPLY_FILT_CNT;
  end

  // the level that argues for leaving the present state
  always_comb begin
    case (sup_state_reg)
      MSP_SUP_ON: sup_against = supply_low;
      default:    sup_against = supply_high;
    endcase
  end

  // qualify counter; a noisy level restarts it, so glitches never switch
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      filt_cnt_reg <= 12'h000;
    end else if (!sup_against || filt_done) begin
      filt_cnt_reg <= 12'h000;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 12'h001;
    end
  end

  // state flips only after the filter has run out
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sup_state_reg <= MSP_SUP_OFF;
    end else if (sup_against && filt_done) begin
      case (sup_state_reg)
        MSP_SUP_ON: sup_state_reg <= MSP_SUP_OFF;
        default:    sup_state_reg <= MSP_SUP_ON;
      endcase
    end
  end

  // active state gates accumulation and the pulse outputs
  assign supply_ok = (sup_state_reg == MSP_SUP_ON);

  ////////////////////////////////////////////////////////////////////////
  // power: one current operand; missing neutral bills on the cal level
  always_comb begin
    cur_sel = sel_b_reg ? current_input_b : current_input_a;
    if (neutral_missing) begin
      inst_power = 48'(mag_big) * 48'(no_neutral_cal_input) >>> 24;
    end else begin
      inst_power = (48'(cur_sel) * 48'(signed'(voltage_sample))) >>> 24;
    end
  end

  // gap to the running average, scaled by the filter depth
  always_comb begin
    avg_step = (40'(inst_power) - avg_power_reg) >>> 8;
  end

  // first-order low-pass gives average power
  always_ff @(posedge core_clk) begin
    if (!rst_n || !supply_ok) begin
      avg_power_reg <= 40'sh00_0000_0000;
    end else if (sample_valid) begin
      avg_power_reg <= avg_power_reg + avg_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulators; rate selects choose the overflow bit
  // calibration rate: one of two overflow bits
  always_comb begin
    if (cal_rate_select) begin
      cal_bit = msp_pkg::CAL_BIT_HI;
    end else begin
      cal_bit = msp_pkg::CAL_BIT_LO;
    end
  end

  // low rate: one of four overflow bits
  always_comb begin
    case ({rate_select_hi, rate_select_lo})
      2'b00:   low_bit = msp_pkg::LOW_BIT_0;
      2'b01:   low_bit = msp_pkg::LOW_BIT_1;
      2'b10:   low_bit = msp_pkg::LOW_BIT_2;
      default: low_bit = msp_pkg::LOW_BIT_3;
    endcase
  end

  // overflow limits for the chosen bits
  always_comb begin
    cal_limit = 40'sh00_0000_0001 <<< cal_bit;
    low_limit = 40'sh00_0000_0001 <<< low_bit;
  end

  // next accumulator values, adding only on a valid sample
  always_comb begin
    cal_step     = sample_valid ? 40'(inst_power) : 40'sh00_0000_0000;
    low_step     = sample_valid ? avg_power_reg : 40'sh00_0000_0000;
    cal_acc_next = cal_acc_reg + cal_step;
    low_acc_next = low_acc_reg + low_step;
  end

  // overflow in either direction fires a pulse
  always_comb begin
    cal_fire = (cal_acc_next >= cal_limit) || (cal_acc_next <= -cal_limit);
    low_fire = (low_acc_next >= low_limit) || (low_acc_next <= -low_limit);
    neg_now  = cal_acc_next[39];
  end

  // no accumulation while the supply is not qualified
  always_ff @(posedge core_clk) begin
    if (!rst_n || !supply_ok) begin
      cal_acc_reg <= 40'sh00_0000_0000;
      low_acc_reg <= 40'sh00_0000_0000;
    end else begin
      cal_acc_reg <= cal_fire ? 40'sh00_0000_0000 : cal_acc_next;
      low_acc_reg <= low_fire ? 40'sh00_0000_0000 : low_acc_next;
    end
  end

  // reverse flag follows sign, updated only on a calibration pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reverse_power_flag <= 1'b0;
    end else if (supply_ok && cal_fire) begin
      reverse_power_flag <= neg_now;
    end
  end

  // trigger for each low-rate output, a first then b
  always_comb begin
    low_trig_a = low_fire && (phase_reg != msp_pkg::MSP_PH_A);
    low_trig_b = low_fire && (phase_reg == msp_pkg::MSP_PH_A);
  end

  // low-rate outputs alternate between a and b
  always_ff @(posedge core_clk) begin
    if (!rst_n || !supply_ok) begin
      phase_reg <= msp_pkg::MSP_PH_IDLE;
    end else if (low_fire) begin
      case (phase_reg)
        msp_pkg::MSP_PH_A: phase_reg <= msp_pkg::MSP_PH_B;
        default:           phase_reg <= msp_pkg::MSP_PH_A;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pulse stretchers, held low while inactive
  // calibration output
  msp_pulse_gen u_cal (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .enable    (supply_ok),
    .trigger   (cal_fire),
    .pulse_out (calibration_pulse_out)
  );
  // low-rate output a
  msp_pulse_gen u_low_a (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .enable    (supply_ok),
    .trigger   (low_trig_a),
    .pulse_out (low_rate_pulse_a)
  );
  // low-rate output b
  msp_pulse_gen u_low_b (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .enable    (supply_ok),
    .trigger   (low_trig_b),
    .pulse_out (low_rate_pulse_b)
  );
endmodule : msp_meter_status
`default_nettype wire

// [core/msp_pkg.sv]
// msp_pkg: constants shared by the meter status and pulse output logic
// assumes a single 20 MHz core clock and signed digitised channel samples
package msp_pkg;
  localparam int unsigned SAMPLE_W      = 24;
  localparam int unsigned ACC_W         = 40;
  localparam int unsigned CLK_HZ        = 20000000;
  // mismatch threshold: difference above |larger| >> 4 (6.25 %)
  localparam int unsigned MISMATCH_SHIFT = 4;
  // supply monitor thresholds in millivolts (about 4 V, with hysteresis)
  localparam logic [12:0] SUPPLY_ON_MV  = 13'h0FD2; // 4050 mV
  localparam logic [12:0] SUPPLY_OFF_MV = 13'h0F6E; // 3950 mV
  // supply filter time in microseconds and derived cycle count
  localparam int unsigned SUPPLY_FILT_US = 100;
  localparam int unsigned SUPPLY_FILT_CYC = (SUPPLY_FILT_US * (CLK_HZ / 1000000));
  localparam logic [11:0] SUPPLY_FILT_CNT = 12'(SUPPLY_FILT_CYC);
  // missing neutral: voltage magnitude below this counts as absent
  localparam logic [23:0] VOLT_ABSENT_LVL = 24'h00_1000;
  // pulse width in cycles for all pulse outputs
  localparam logic [7:0]  PULSE_WIDTH   = 8'h0A;
  // calibration output: accumulator bit giving rate, scf low/high
  localparam int unsigned CAL_BIT_LO    = 26;
  localparam int unsigned CAL_BIT_HI    = 24;
  // low-rate outputs: accumulator bit per rate setting (s1,s0)
  localparam int unsigned LOW_BIT_0     = 38;
  localparam int unsigned LOW_BIT_1     = 37;
  localparam int unsigned LOW_BIT_2     = 36;
  localparam int unsigned LOW_BIT_3     = 35;
  typedef enum logic [1:0] {MSP_PH_IDLE, MSP_PH_A, MSP_PH_B} msp_phase_e;
endpackage : msp_pkg

// [core/msp_pulse_gen.sv]
// msp_pulse_gen: stretches a one-cycle request into a fixed-width high pulse
// assumes requests spaced further apart than the pulse width
`timescale 1ns/1ps
`default_nettype none
module msp_pulse_gen (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic trigger,
  output var  logic pulse_out
);
  logic [7:0] count_reg;

  // width counter, cleared while disabled
  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      count_reg <= 8'h00;
    end else if (trigger) begin
      count_reg <= msp_pkg::PULSE_WIDTH;
    end else if (count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  // registered output, low while disabled
  always_ff @(posedge core_clk) begin
    if (!rst_n || !enable) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= trigger || (count_reg > 8'h01);
    end
  end
endmodule : msp_pulse_gen
`default_nettype wire

// [testbench/msp_meter_status_asserts.sv]
// msp_meter_status_asserts: port-level checks of the status and pulse block
// assumes it is bound onto msp_meter_status
`timescale 1ns/1ps
`default_nettype none
module msp_meter_status_asserts (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        sample_valid,
  input wire logic [23:0] current_input_a,
  input wire logic [23:0] current_input_b,
  input wire logic [23:0] voltage_sample,
  input wire logic [12:0] supply_mv,
  input wire logic        fault_alarm,
  input wire logic        reverse_power_flag,
  input wire logic        calibration_pulse_out,
  input wire logic        low_rate_pulse_a,
  input wire logic        low_rate_pulse_b,
  input wire logic        supply_ok,
  input wire logic        using_input_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // cycles the supply has stood at or above the on level
  logic [11:0] above_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n || supply_mv < msp_pkg::SUPPLY_ON_MV) above_reg <= 12'h000;
    else if (above_reg != 12'hFFF) above_reg <= above_reg + 12'h001;
  end
  ////////////////////////////////////////
  property p_diff; sample_valid && supply_ok && current_input_a != 24'h00_0000
    && current_input_b == 24'h00_0000 |=> fault_alarm; endproperty
  a_diff: assert property (p_diff) else $error("alarm missing on mismatch");
  property p_neutral; sample_valid && supply_ok && voltage_sample == 24'h00_0000 |=> fault_alarm; endproperty
  a_neutral: assert property (p_neutral) else $error("alarm missing without voltage");
  property p_clear; sample_valid && supply_ok && current_input_a == current_input_b && !voltage_sample[23]
    && voltage_sample[22:12] != 11'h000 |=> !fault_alarm; endproperty
  a_clear: assert property (p_clear) else $error("alarm stuck high");
  property p_rev; $changed(reverse_power_flag) |-> $rose(calibration_pulse_out); endproperty
  a_rev: assert property (p_rev) else $error("reverse flag moved without pulse");
  // cycles the calibration output has stood high so far
  logic [7:0] cal_hi_reg;
  always_ff @(posedge core_clk) begin
    if (!rst_n || !calibration_pulse_out) cal_hi_reg <= 8'h00;
    else if (cal_hi_reg != 8'hFF) cal_hi_reg <= cal_hi_reg + 8'h01;
  end
  property p_width; disable iff (!rst_n || !supply_ok)
    $fell(calibration_pulse_out) |-> cal_hi_reg == msp_pkg::PULSE_WIDTH; endproperty
  a_width: assert property (p_width) else $error("calibration pulse width wrong");
  property p_width_max; calibration_pulse_out |-> cal_hi_reg < msp_pkg::PULSE_WIDTH; endproperty
  a_width_max: assert property (p_width_max) else $error("calibration pulse too long");
  property p_pair; $rose(low_rate_pulse_b) |-> !low_rate_pulse_a; endproperty
  a_pair: assert property (p_pair) else $error("low rate pulses overlap");
  property p_idle; !supply_ok && !$past(supply_ok)
    |-> !calibration_pulse_out && !low_rate_pulse_a && !low_rate_pulse_b; endproperty
  a_idle: assert property (p_idle) else $error("pulse while inactive");
  property p_qual; $rose(supply_ok) |-> above_reg >= 12'h7CF; endproperty
  a_qual: assert property (p_qual) else $error("supply qualified too soon");
  property p_bill; sample_valid && supply_ok && current_input_a == 24'h00_0000
    && current_input_b != 24'h00_0000 |=> using_input_b; endproperty
  a_bill: assert property (p_bill) else $error("billing input not b");
endmodule : msp_meter_status_asserts
bind msp_meter_status msp_meter_status_asserts u_chk (.core_clk, .rst_n, .sample_valid, .current_input_a,
  .current_input_b, .voltage_sample, .supply_mv, .fault_alarm, .reverse_power_flag, .calibration_pulse_out,
  .low_rate_pulse_a, .low_rate_pulse_b, .supply_ok, .using_input_b);
`default_nettype wire

// [testbench/msp_pulse_counter.sv]
// msp_pulse_counter: counts rising edges of a pulse output like a meter counter
// assumes every pulse is at least one core clock wide
`timescale 1ns/1ps
`default_nettype none
module msp_pulse_counter (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        pulse_in,
  output var  logic [15:0] count
);
  logic last_reg;
  // edge detect and count
  always_ff @(posedge core_clk) begin
    last_reg <= pulse_in;
    if (!rst_n) count <= 16'h0000;
    else if (pulse_in && !last_reg) count <= count + 16'h0001;
  end
endmodule : msp_pulse_counter
`default_nettype wire

// [testbench/msp_meter_status_tb.sv]
// msp_meter_status_tb: random and corner stimulus with self-checks
// assumes the pulse counter model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module msp_meter_status_tb;
  logic        core_clk = 1'b0, rst_n = 1'b0, sample_valid = 1'b0;
  logic [23:0] current_input_a = 24'h00_0000, current_input_b = 24'h00_0000;
  logic [23:0] voltage_sample = 24'h00_0000, no_neutral_cal_input = 24'h20_0000;
  logic [12:0] supply_mv = 13'h0F3C;
  logic        cal_rate_select = 1'b0, rate_select_hi = 1'b0, rate_select_lo = 1'b0;
  logic        fault_alarm, reverse_power_flag, calibration_pulse_out, supply_ok;
  logic        low_rate_pulse_a, low_rate_pulse_b, using_input_b;
  logic [15:0] n_cf, n_la, n_lb;
  logic [23:0] a, b, t;
  int          fails = 0, comparisons = 0, c, d;
  always #25 core_clk = ~core_clk;
  msp_meter_status dut (.core_clk, .rst_n, .sample_valid, .current_input_a, .current_input_b,
    .voltage_sample, .no_neutral_cal_input, .supply_mv, .cal_rate_select, .rate_select_hi,
    .rate_select_lo, .fault_alarm, .reverse_power_flag, .calibration_pulse_out,
    .low_rate_pulse_a, .low_rate_pulse_b, .supply_ok, .using_input_b);
  msp_pulse_counter u_cf (.core_clk, .rst_n, .pulse_in(calibration_pulse_out), .count(n_cf));
  msp_pulse_counter u_la (.core_clk, .rst_n, .pulse_in(low_rate_pulse_a), .count(n_la));
  msp_pulse_counter u_lb (.core_clk, .rst_n, .pulse_in(low_rate_pulse_b), .count(n_lb));
  ////////////////////////////////////////
  // expected alarm: difference above one sixteenth of the larger input
  function automatic logic exp_alarm(logic [23:0] x, logic [23:0] y);
    return ((x > y) ? x - y : y - x) > (((x > y) ? x : y) >> 4);
  endfunction : exp_alarm
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // compare on the falling edge, return on the next rising edge
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    @(negedge core_clk);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
    @(posedge core_clk);
  endtask : chk
  task automatic wait_cf(int k);
    int c0;
    c0 = n_cf;
    for (int i = 0; i < 20000 && n_cf < c0 + k; i++) @(posedge core_clk);
    chk("cf_seen", 1, n_cf >= c0 + k);
  endtask : wait_cf
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(10));
    cyc(6);
    rst_n <= 1'b1;
    sample_valid <= 1'b1;
    current_input_a <= 24'h40_0000;
    current_input_b <= 24'h40_0000;
    voltage_sample <= 24'h40_0000;
    chk("alarm_idle", 0, fault_alarm);
    cyc(1500);
    chk("cf_off", 0, n_cf);
    supply_mv <= 13'h1388;
    cyc(1500);
    chk("ok_early", 0, supply_ok);
    cyc(700);
    chk("ok_late", 1, supply_ok);
    supply_mv <= 13'h0FA0;
    cyc(2100);
    chk("ok_hyst", 1, supply_ok);
    for (int s = 0; s < 2; s++) begin
      cal_rate_select <= s[0];
      c = n_cf;
      cyc(3000);
      chk("cf_rate", 1, n_cf > c);
    end
    for (int s = 0; s < 4; s++) begin
      {rate_select_hi, rate_select_lo} <= s[1:0];
      cyc(2000);
    end
    // full-scale power on the fastest low-rate setting: a pulse, then b
    cal_rate_select <= 1'b0;
    current_input_a <= 24'h7F_FFFF;
    current_input_b <= 24'h7F_FFFF;
    voltage_sample <= 24'h7F_FFFF;
    for (int i = 0; i < 20000 && n_lb == 16'h0000; i++) @(posedge core_clk);
    chk("low_b_seen", 1, n_lb != 16'h0000);
    d = int'(n_la) - int'(n_lb);
    chk("low_alt", 1, d >= 0 && d <= 1);
    for (int i = 0; i < 24; i++) begin
      a = 24'($urandom_range(65535, 4096)) << 4;
      b = a - (a >> 4) - ((i % 2) ? 24'h00_0000 : 24'h00_0010);
      if (i >= 22) b = 24'h00_0000;
      if (i == 23 || (i < 22 && $urandom_range(1, 0) == 1)) begin
        t = a;
        a = b;
        b = t;
      end
      current_input_a <= a;
      current_input_b <= b;
      cyc(3);
      chk("alarm", exp_alarm(a, b), fault_alarm);
      if (exp_alarm(a, b)) chk("bill_b", b > a, using_input_b);
    end
    current_input_a <= 24'h40_0000;
    current_input_b <= 24'h40_0000;
    cyc(3);
    chk("alarm_clr", 0, fault_alarm);
    voltage_sample <= 24'h00_0000;
    cyc(3);
    chk("neutral", 1, fault_alarm);
    voltage_sample <= 24'h40_0000;
    cyc(3);
    chk("neutral_clr", 0, fault_alarm);
    voltage_sample <= 24'hC0_0000;
    wait_cf(2);
    chk("rev_set", 1, reverse_power_flag);
    voltage_sample <= 24'h40_0000;
    wait_cf(2);
    chk("rev_clr", 0, reverse_power_flag);
    supply_mv <= 13'h0F3C;
    cyc(2200);
    chk("ok_drop", 0, supply_ok);
    c = n_cf;
    cyc(1000);
    chk("cf_held", c, n_cf);
    supply_mv <= 13'h1388;
    wait_cf(1);
    test_done;
  end
  // watchdog against a hang
  initial begin
    cyc(60000);
    fails++;
    test_done;
  end
endmodule : msp_meter_status_tb
`default_nettype wire
